// ### dv/cmrs_core_sva.sv
/* assertions on the apb and pin ports of cmrs_core.
   assumes one clock and a synchronous active-high reset. */
`timescale 1ns/1ps
`default_nettype none
module cmrs_core_sva (
	// clock and reset
	input wire logic        core_clk_i,
	input wire logic        sys_rst_i,
	// apb
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	// pins
	input wire logic        wake_pin_i,
	input wire logic        halted_o,
	input wire logic        instr_cycle_o
);
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (sys_rst_i);
	wire xfer = psel && penable;
	rdy_in_access_a: assert property (xfer |-> pready)
		else $error("pready low in access");
	rdata_idle_a: assert property (!(xfer && !pwrite) |-> prdata == 32'h0)
		else $error("prdata not zero");
	unmapped_err_a: assert property (xfer && paddr >= 8'h20 && paddr < 8'h80 |-> pslverr)
		else $error("unmapped access accepted");
	wdog_write_err_a: assert property (xfer && pwrite && paddr == 8'h1c |-> pslverr)
		else $error("watchdog write accepted");
	cycle_spacing_a: assert property (instr_cycle_o |=> !instr_cycle_o [*3])
		else $error("instruction cycles too close");
	halt_quiet_a: assert property (halted_o && $past(halted_o) && $past(halted_o, 2)
		|-> !instr_cycle_o)
		else $error("instruction cycle while halted");
	ctrl_halt_rd_a: assert property (xfer && !pwrite && paddr == 8'h00
		|-> prdata[0] == $past(halted_o)) else $error("ctrl halt bit wrong");
	status_halt_rd_a: assert property (xfer && !pwrite && paddr == 8'h0c
		|-> prdata[9] == $past(halted_o)) else $error("status halt bit wrong");
	halt_issue_err_a: assert property (xfer && pwrite && paddr == 8'h04
		&& $past(halted_o) |-> pslverr) else $error("issue while halted accepted");
	cover property ($rose(halted_o));
	cover property ($fell(halted_o));
	cover property (xfer && pslverr);
endmodule
`default_nettype wire

// ### dv/tb_core_move_return_sleep_ops.sv
/* self-checking bench for cmrs_core through its apb port.
   assumes the checker is compiled first and bound below. */
`timescale 1ns/1ps
`default_nettype none
`include "cmrs_consts.vh"
module tb_core_move_return_sleep_ops;
	logic        core_clk_i = 0;
	logic        sys_rst_i = 1;
	logic        psel = 0, penable = 0, pwrite = 0, wake_pin_i = 0;
	logic [7:0]  paddr = 0;
	logic [31:0] pwdata = 0, prdata, rd, pcv;
	logic        pready, pslverr, er, halted_o, instr_cycle_o;
	int          err_count = 0, comparisons = 0, pulses = 0, p0;
	always #4 core_clk_i = ~core_clk_i;
	always @(posedge core_clk_i) if (instr_cycle_o === 1'b1) pulses <= pulses + 1;
	cmrs_core u_dut (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .wake_pin_i(wake_pin_i),
		.halted_o(halted_o), .instr_cycle_o(instr_cycle_o));
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			err_count++;
			$display("[FAIL] %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic close_out;
		$display("mismatches %0d comparisons %0d", err_count, comparisons);
		if (err_count == 0 && comparisons > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	// answer taken at the rising edge where pready is sampled high
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk_i);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk_i);
		penable <= 1;
		do @(posedge core_clk_i); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	task automatic rc(input logic [7:0] a, input logic [31:0] e, input string n);
		apb(0, a, 0);
		chk(n, e, rd);
	endtask
	task automatic idle;
		rd = 32'h100;
		for (int i = 0; i < 40 && rd[8] !== 1'b0; i++) apb(0, `CMRS_OFF_STATUS, 0);
	endtask
	task automatic ex(input logic [11:0] op);
		apb(1, `CMRS_OFF_INSTR, {20'h0, op});
		idle();
	endtask
	// skips a pulse from the enable at the issuing edge
	task automatic waitp;
		@(negedge core_clk_i);
		do @(negedge core_clk_i); while (instr_cycle_o !== 1'b1);
	endtask
	initial begin
		repeat (20000) @(posedge core_clk_i);
		err_count++;
		close_out();
	end
	initial begin
		repeat (10) @(posedge core_clk_i);
		sys_rst_i <= 0;
		rc(`CMRS_OFF_OPTION, 32'hff, "option");
		rc(`CMRS_OFF_STATUS, 32'h18, "status");
		apb(1, `CMRS_OFF_STATUS, 32'h5);
		ex(12'hca5);
		rc(`CMRS_OFF_ACC, 32'ha5, "acc");
		rc(`CMRS_OFF_STATUS, 32'h1d, "status");
		ex(12'h002);
		rc(`CMRS_OFF_OPTION, 32'ha5, "option");
		rc(`CMRS_OFF_STATUS, 32'h1d, "status");
		apb(1, 8'h8c, 32'h0);
		apb(1, 8'hfc, 32'h3c);
		apb(1, 8'h94, 32'h80);
		ex(12'h21f);
		rc(`CMRS_OFF_ACC, 32'h3c, "acc");
		rc(`CMRS_OFF_STATUS, 32'h19, "status");
		ex(12'h203);
		rc(`CMRS_OFF_STATUS, 32'h1d, "status");
		ex(12'h225);
		rc(`CMRS_OFF_ACC, 32'h0, "acc");
		rc(8'h94, 32'h80, "file5");
		rc(`CMRS_OFF_STATUS, 32'h19, "status");
		apb(1, 8'h9c, 32'h41);
		ex(12'h347);
		rc(`CMRS_OFF_ACC, 32'h83, "acc");
		rc(8'h9c, 32'h41, "file7");
		rc(`CMRS_OFF_STATUS, 32'h18, "status");
		ex(12'h365);
		rc(8'h94, 32'h0, "file5");
		rc(`CMRS_OFF_STATUS, 32'h19, "status");
		apb(1, `CMRS_OFF_STACK, 32'h123);
		apb(1, `CMRS_OFF_INSTR, 32'h85a);
		waitp();
		apb(1, `CMRS_OFF_INSTR, 32'h0);
		chk("busy refusal", 32'h1, {31'h0, er});
		idle();
		rc(`CMRS_OFF_ACC, 32'h5a, "acc");
		rc(`CMRS_OFF_PC, 32'h123, "pc");
		apb(1, `CMRS_OFF_INSTR, 32'h0);
		waitp();
		apb(1, `CMRS_OFF_INSTR, 32'h0);
		chk("nop refusal", 32'h0, {31'h0, er});
		idle();
		apb(0, `CMRS_OFF_PC, 0);
		pcv = {21'h0, rd[10:0] + 11'h1};
		ex(12'h000);
		rc(`CMRS_OFF_PC, pcv, "pc");
		rc(`CMRS_OFF_STATUS, 32'h19, "status");
		ex(12'h003);
		rc(`CMRS_OFF_STATUS, 32'h211, "status");
		rc(`CMRS_OFF_WDOG, 32'h0, "watchdog");
		p0 = pulses;
		repeat (20) @(posedge core_clk_i);
		chk("pulses", p0, pulses);
		apb(1, `CMRS_OFF_INSTR, 32'h0);
		chk("halt refusal", 32'h1, {31'h0, er});
		apb(1, `CMRS_OFF_CTRL, 32'h1);
		rc(`CMRS_OFF_CTRL, 32'h0, "ctrl");
		ex(12'h003);
		@(posedge core_clk_i);
		wake_pin_i <= 1;
		repeat (6) @(posedge core_clk_i);
		rc(`CMRS_OFF_STATUS, 32'h91, "status");
		ex(12'h003);
		rc(`CMRS_OFF_STATUS, 32'h291, "status");
		apb(0, 8'h40, 0);
		chk("unmapped", 32'h1, {31'h0, er});
		close_out();
	end
endmodule
bind cmrs_core cmrs_core_sva u_sva (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.prdata(prdata), .pready(pready), .pslverr(pslverr), .wake_pin_i(wake_pin_i),
	.halted_o(halted_o), .instr_cycle_o(instr_cycle_o));
`default_nettype wire

// ### inc/cmrs_consts.vh
/*
 * constants of the move / return / halt execution core: register offsets,
 * field positions, reset values, opcode patterns and timing counts.
 * assumes inclusion by bare name from the logic files.
 */
`ifndef CMRS_CONSTS_VH
`define CMRS_CONSTS_VH

// apb byte offsets
`define CMRS_OFF_CTRL     8'h00
`define CMRS_OFF_INSTR    8'h04
`define CMRS_OFF_ACC      8'h08
`define CMRS_OFF_STATUS   8'h0c
`define CMRS_OFF_OPTION   8'h10
`define CMRS_OFF_PC       8'h14
`define CMRS_OFF_STACK    8'h18
`define CMRS_OFF_WDOG     8'h1c
`define CMRS_OFF_FILE     8'h80

// status fields
`define CMRS_ST_CARRY     0
`define CMRS_ST_NULL      2
`define CMRS_ST_PDOWN     3
`define CMRS_ST_TOUT      4
`define CMRS_ST_WAKE      7
`define CMRS_ST_BUSY      8
`define CMRS_ST_HALT      9
`define CMRS_CTRL_WAKE    0

// reset values
`define CMRS_RST_OPTION   8'hff
`define CMRS_RST_PC       11'h7ff

// opcode patterns, full 12-bit words or their 6-bit and 4-bit high fields
`define CMRS_OP_NOP       12'h000
`define CMRS_OP_OPTION    12'h002
`define CMRS_OP_HALT      12'h003
`define CMRS_OP_MOVE_HI   6'h08
`define CMRS_OP_ROTL_HI   6'h0d
`define CMRS_OP_RET_HI    4'h8
`define CMRS_OP_LIT_HI    4'hc

// divider terminal count; one instruction cycle is four core clocks
`define CMRS_CLK_PER_CYC  2'd3

`endif

// ### logic/cmrs_core.v
/*
 * execution core for move, literal, option-load, return, rotate, no-op
 * and halt instructions, issued one at a time over an apb slave.
 * assumes a single 125 mhz clock, synchronous active-high reset and an
 * asynchronous wake pin that is synchronised here.
 */
// Functional notes
// - file_move reads the 8-bit file register named by the 5-bit address unchanged.
// - file_move with destination bit 0 writes the accumulator, with 1 the file register.
// - file_move always updates result_null_flag from the moved value, also on write-back.
// - literal_load puts its 8-bit literal into the accumulator and touches no flag.
// - the option-load copies the accumulator into the option register, no flag touched.
// - literal_return loads its literal into the accumulator and the pc from return_stack_head.
// - literal_return occupies two instruction cycles and nothing completes in the second.
// - halt clears the watchdog_timer count and its prescaler to zero.
// - halt sets timeout_flag, clears powerdown_flag and leaves pin_change_wake_flag alone.
// - after halt the instruction clock stops and execution is suspended.
// - left_rotate_carry shifts left with old bit 7 into the carry and old carry into bit 0.
// - left_rotate_carry with destination bit 0 writes the accumulator, with 1 the source.
`timescale 1ns/1ps
`default_nettype none
`include "cmrs_consts.vh"

module cmrs_core (
	// clock and reset
	input  wire        core_clk_i,
	input  wire        sys_rst_i,
	// apb slave
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [7:0]  paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output reg         pready,
	output reg         pslverr,
	// pins
	input  wire        wake_pin_i,
	output reg         halted_o,
	output reg         instr_cycle_o
);

	localparam ST_IDLE = 2'd0;
	localparam ST_PEND = 2'd1;
	localparam ST_TAIL = 2'd2;

	// decoded access helper, used by read and write paths
	function is_file;
		input [7:0] a;
		begin
			is_file = (a >= `CMRS_OFF_FILE) && (a[1:0] == 2'b00);
		end
	endfunction

	reg  [1:0]  state;
	reg  [1:0]  div_cnt;
	reg  [11:0] instr;
	reg  [7:0]  acc;
	reg  [7:0]  option;
	reg  [10:0] pc;
	reg  [10:0] stk_head;
	// two-level stack: a third push silently drops the oldest entry
	reg  [10:0] stk_next;
	reg  [7:0]  wdog_cnt;
	reg  [7:0]  wdog_pre;
	reg         carry;
	reg         null_flag;
	reg         pdown;
	reg         tout;
	reg         wake_flag;
	reg         wake_s1;
	reg         wake_s2;
	reg         wake_s3;

	wire        cen = (div_cnt == `CMRS_CLK_PER_CYC) && !halted_o;
	wire        busy = (state != ST_IDLE);
	wire        setup = psel && !penable;
	wire        acc_wr = psel && penable && pwrite;
	wire        wake_edge = wake_s2 ^ wake_s3;

	// decode of the held instruction
	wire [4:0]  f_addr = instr[4:0];
	wire        dest_f = instr[5];
	wire [7:0]  lit = instr[7:0];
	wire        op_move = (instr[11:6] == `CMRS_OP_MOVE_HI);
	wire        op_rotl = (instr[11:6] == `CMRS_OP_ROTL_HI);
	wire        op_ret = (instr[11:8] == `CMRS_OP_RET_HI);
	wire        op_lit = (instr[11:8] == `CMRS_OP_LIT_HI);
	wire        op_opt = (instr == `CMRS_OP_OPTION);
	wire        op_halt = (instr == `CMRS_OP_HALT);
	wire        exec = cen && (state == ST_PEND);

	// file bank ports
	wire [7:0]  f_rd;
	wire [7:0]  rot_val = {f_rd[6:0], carry};
	wire        core_fwr = exec && dest_f && (op_move || op_rotl);
	// software file writes are held off while an instruction owns the bank
	wire        apb_fwr = acc_wr && is_file(paddr) && !busy;
	// the core owns the read port while busy, so file reads are refused then
	wire        bank_we = core_fwr || apb_fwr;
	wire [4:0]  bank_wa = core_fwr ? f_addr : paddr[6:2];
	wire [7:0]  bank_wd = core_fwr ? (op_move ? f_rd : rot_val) : pwdata[7:0];
	wire [4:0]  bank_ra = busy ? f_addr : paddr[6:2];

	cmrs_file_bank u_bank (
		.core_clk_i (core_clk_i),
		.sys_rst_i  (sys_rst_i),
		.wr_en_i    (bank_we),
		.wr_addr_i  (bank_wa),
		.wr_data_i  (bank_wd),
		.rd_addr_i  (bank_ra),
		.rd_data_o  (f_rd)
	);

	// wake pin synchroniser; only the second and third stage are compared
	always @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			wake_s1 <= 1'b0;
			wake_s2 <= 1'b0;
			wake_s3 <= 1'b0;
		end else begin
			wake_s1 <= wake_pin_i;
			wake_s2 <= wake_s1;
			wake_s3 <= wake_s2;
		end
	end

	// instruction clock divider, held at zero while halted
	always @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			div_cnt       <= 2'd0;
			instr_cycle_o <= 1'b0;
		end else if (halted_o) begin
			div_cnt       <= 2'd0;
			instr_cycle_o <= 1'b0;
		end else begin
			div_cnt       <= div_cnt + 2'd1;
			instr_cycle_o <= cen;
		end
	end

	// sequencer: issue, execute, second cycle of a return
	always @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			state <= ST_IDLE;
			instr <= `CMRS_OP_NOP;
		end else begin
			case (state)
			ST_IDLE: begin
				if (acc_wr && paddr == `CMRS_OFF_INSTR && !halted_o) begin
					instr <= pwdata[11:0];
					state <= ST_PEND;
				end
			end
			ST_PEND: begin
				if (cen) begin
					state <= op_ret ? ST_TAIL : ST_IDLE;
				end
			end
			ST_TAIL: begin
				// dead cycle: the pipeline refill after the return
				if (cen) begin
					state <= ST_IDLE;
				end
			end
			default: begin
				state <= ST_IDLE;
			end
			endcase
		end
	end

	// accumulator, option, pc and stack
	always @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			acc      <= 8'h00;
			option   <= `CMRS_RST_OPTION;
			pc       <= `CMRS_RST_PC;
			stk_head <= 11'h000;
			stk_next <= 11'h000;
		end else if (exec) begin
			pc <= pc + 11'd1;
			if (op_move && !dest_f) begin
				acc <= f_rd;
			end else if (op_rotl && !dest_f) begin
				acc <= rot_val;
			end else if (op_lit) begin
				acc <= lit;
			end else if (op_opt) begin
				option <= acc;
			end else if (op_ret) begin
				acc      <= lit;
				pc       <= stk_head;
				stk_head <= stk_next;
			end
		end else if (acc_wr && !busy) begin
			if (paddr == `CMRS_OFF_ACC) begin
				acc <= pwdata[7:0];
			end else if (paddr == `CMRS_OFF_OPTION) begin
				option <= pwdata[7:0];
			end else if (paddr == `CMRS_OFF_PC) begin
				pc <= pwdata[10:0];
			end else if (paddr == `CMRS_OFF_STACK) begin
				stk_next <= stk_head;
				stk_head <= pwdata[10:0];
			end
		end
	end

	// status flags; hardware events win over software writes
	always @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			carry     <= 1'b0;
			null_flag <= 1'b0;
			pdown     <= 1'b1;
			tout      <= 1'b1;
			wake_flag <= 1'b0;
		end else begin
			if (exec && op_move) begin
				null_flag <= (f_rd == 8'h00);
			end else if (acc_wr && !busy && paddr == `CMRS_OFF_STATUS) begin
				null_flag <= pwdata[`CMRS_ST_NULL];
			end
			if (exec && op_rotl) begin
				carry <= f_rd[7];
			end else if (acc_wr && !busy && paddr == `CMRS_OFF_STATUS) begin
				carry <= pwdata[`CMRS_ST_CARRY];
			end
			if (exec && op_halt) begin
				tout  <= 1'b1;
				pdown <= 1'b0;
			end
		end
	end

	// wake flag: a pin edge while halted wins over a clear in the same cycle
	always @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			wake_flag <= 1'b0;
		end else if (halted_o && wake_edge) begin
			wake_flag <= 1'b1;
		end else if (acc_wr && paddr == `CMRS_OFF_STATUS && pwdata[`CMRS_ST_WAKE]) begin
			wake_flag <= 1'b0;
		end
	end

	// watchdog count and prescaler; both stand still while halted
	always @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			wdog_cnt <= 8'h00;
			wdog_pre <= 8'h00;
		end else if (exec && op_halt) begin
			wdog_cnt <= 8'h00;
			wdog_pre <= 8'h00;
		end else if (cen) begin
			// prescaler wraps into the count; no timeout action in this block
			wdog_pre <= wdog_pre + 8'h01;
			if (wdog_pre == 8'hff) begin
				wdog_cnt <= wdog_cnt + 8'h01;
			end
		end
	end

	// halt state: entered by the halt instruction, left by pin or software
	always @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			halted_o <= 1'b0;
		end else if (exec && op_halt) begin
			halted_o <= 1'b1;
		end else if (halted_o && (wake_edge ||
		                          (acc_wr && paddr == `CMRS_OFF_CTRL && pwdata[`CMRS_CTRL_WAKE]))) begin
			halted_o <= 1'b0;
		end
	end

	// apb answer, registered in the setup phase so access sees it at once
	always @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			prdata  <= 32'h0000_0000;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready  <= 1'b1;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
			if (setup) begin
				if (paddr == `CMRS_OFF_CTRL) begin
					prdata <= {31'h0, halted_o};
				end else if (paddr == `CMRS_OFF_INSTR) begin
					prdata  <= {20'h0, instr};
					pslverr <= pwrite && (busy || halted_o);
				end else if (paddr == `CMRS_OFF_ACC) begin
					prdata  <= {24'h0, acc};
					pslverr <= pwrite && busy;
				end else if (paddr == `CMRS_OFF_STATUS) begin
					prdata <= {22'h0,
					           halted_o,
					           busy,
					           wake_flag,
					           2'b00,
					           tout,
					           pdown,
					           null_flag,
					           1'b0,
					           carry};
				end else if (paddr == `CMRS_OFF_OPTION) begin
					prdata  <= {24'h0, option};
					pslverr <= pwrite && busy;
				end else if (paddr == `CMRS_OFF_PC) begin
					prdata  <= {21'h0, pc};
					pslverr <= pwrite && busy;
				end else if (paddr == `CMRS_OFF_STACK) begin
					prdata  <= {21'h0, stk_head};
					pslverr <= pwrite && busy;
				end else if (paddr == `CMRS_OFF_WDOG) begin
					prdata  <= {16'h0, wdog_pre, wdog_cnt};
					pslverr <= pwrite;
				end else if (is_file(paddr)) begin
					prdata  <= {24'h0, f_rd};
					pslverr <= busy;
				end else begin
					pslverr <= 1'b1;
				end
				// read data only shows during a read access
				if (pwrite) begin
					prdata <= 32'h0000_0000;
				end
			end
		end
	end

endmodule

`default_nettype wire

// ### logic/cmrs_file_bank.v
/*
 * 32 x 8 file register bank, one write port, asynchronous read port.
 * assumes the caller never asserts the write from two sources at once.
 */
`timescale 1ns/1ps
`default_nettype none

module cmrs_file_bank (
	// clock and reset
	input  wire       core_clk_i,
	input  wire       sys_rst_i,
	// write port
	input  wire       wr_en_i,
	input  wire [4:0] wr_addr_i,
	input  wire [7:0] wr_data_i,
	// read port
	input  wire [4:0] rd_addr_i,
	output wire [7:0] rd_data_o
);

	reg [7:0] mem [0:31];

	genvar gi;
	generate
		for (gi = 0; gi < 32; gi = gi + 1) begin : g_cell
			always @(posedge core_clk_i) begin
				if (sys_rst_i) begin
					mem[gi] <= 8'h00;
				end else if (wr_en_i && wr_addr_i == gi) begin
					mem[gi] <= wr_data_i;
				end
			end
		end
	endgenerate

	assign rd_data_o = mem[rd_addr_i];

endmodule

`default_nettype wire
